// *** bcpc_div_if.sv ***
// tick divider connection between the control top and its dividers
`timescale 1ns/1ps
interface bcpc_div_if;
  logic tick_in;
  logic [7:0] div;
  logic tick_out;
  modport master (output tick_in, output div, input tick_out);
  modport slave (input tick_in, input div, output tick_out);
endinterface

// *** bcpc_divider.sv ***
// tick divider: one output pulse for every div input ticks
`timescale 1ns/1ps
module bcpc_divider import bcpc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // divider link
  bcpc_div_if.slave d
);
  logic [7:0] cnt_r;
  logic tick_out_r;
  logic last;

  // a divide value of zero behaves as one, so the tick never stalls
  assign last = (d.div == 8'h00) || (cnt_r >= d.div - 8'h01);
  assign d.tick_out = tick_out_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick_out_r <= 1'b0;
    end else begin
      tick_out_r <= d.tick_in && last;
      if (d.tick_in) begin
        cnt_r <= last ? 8'h00 : cnt_r + 8'h01;
      end
    end
  end
endmodule

// *** bcpc_pkg.sv ***
// constants, register map and types for boot, clock and power control
package bcpc_pkg;
  // ********************************************************
  // register map (byte addresses)
  // ********************************************************
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CLK_OUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BOOT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_CLK_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CC_OSC_DISC_POS = 0;
  localparam int CC_VCO_BYP_POS = 1;
  localparam int CC_EXT_OSC_POS = 2;
  localparam int CC_FBDIV_POS = 8;
  localparam int CC_FBDIV_W = 6;
  localparam int CC_SLOW_POS = 16;
  localparam int CC_SLOW_W = 4;
  localparam int PC_MODE_POS = 0;
  localparam int PC_STOP_POS = 4;
  localparam int NUM_COMP = 4;
  localparam int CO_EN_POS = 0;
  localparam int CO_TOGGLE_POS = 1;
  localparam int CO_SRC_POS = 2;
  localparam int BS_MODE_POS = 0;
  localparam int BS_VALID_POS = 3;
  localparam int BS_PROT_POS = 4;
  localparam int BS_PC_POS = 16;
  localparam int CS_MODE_POS = 0;
  localparam int CS_OSC_RUN_POS = 2;
  localparam int CS_LOCK_POS = 3;
  localparam int CS_PWR_POS = 4;
  localparam int CS_FREQ_POS = 8;
  localparam int NUM_IRQ = 4;
  localparam int IRQ_OSC_FAIL = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_DBG_REFUSED = 2;
  localparam int IRQ_WAKE = 3;
  // ********************************************************
  // reset values and fixed figures
  // ********************************************************
  localparam logic [5:0] FBDIV_RST = 6'h10;
  localparam logic [3:0] SLOW_RST = 4'h1;
  localparam logic [15:0] PC_START = 16'h0000;
  localparam logic [1:0] P_FACTOR = 2'h1;
  localparam logic [1:0] K_FACTOR = 2'h2;
  localparam logic [7:0] PERIPH_DIV = 8'h03;
  localparam logic [19:0] INT_OSC_KHZ = 20'h02710;
  localparam logic [1:0] BOOT_SETTLE_CYC = 2'h2;
  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    BCPC_BOOT_USER = 3'b000,
    BCPC_BOOT_LOADER = 3'b001,
    BCPC_BOOT_DEBUG = 3'b010,
    BCPC_BOOT_JTAG_USER = 3'b011
  } bcpc_boot_e;
  typedef enum logic [1:0] {
    BCPC_CM_PLL = 2'b00,
    BCPC_CM_PRESCALER = 2'b01,
    BCPC_CM_PLL_BASE = 2'b10
  } bcpc_clkmode_e;
  typedef enum logic [1:0] {
    BCPC_PWR_ACTIVE = 2'b00,
    BCPC_PWR_IDLE = 2'b01,
    BCPC_PWR_SLOW = 2'b10,
    BCPC_PWR_DOWN = 2'b11
  } bcpc_pwr_e;
endpackage

// *** bcpc_strap_model.sv ***
// board model driving the boot straps and flash protection level
`timescale 1ns/1ps
module bcpc_strap_model (
  // clock and requested straps
  input wire logic clk,
  input wire logic [3:0] cfg,
  // strap pins
  output logic boot_select_pin,
  output logic test_mode_pin,
  output logic port_zero_pin_zero,
  output logic flash_protected
);
  // straps move only after an edge, so they are settled long before reset ends
  initial {boot_select_pin, test_mode_pin, port_zero_pin_zero, flash_protected} = 4'h8;
  always @(posedge clk) begin
    {boot_select_pin, test_mode_pin, port_zero_pin_zero, flash_protected} <= cfg;
  end
endmodule

// *** bcpc_top.sv ***
// boot selection, clock mode, clock distribution and power saving control
//
// Overview of operation
// - boot option taken from three pins
// - boot high, test low: user; both low: loader
// - test pin high, third pin low: debug or JTAG user
// - protected flash blocks debug mode entry
// - internal oscillator after reset, external selectable
// - watch oscillator run and PLL lock
// - disconnect and bypass bits decode clock mode
// - system frequency formula per clock mode
// - PLL mode only with both bypasses off
// - P is 1, K is 2, N programmable
// - all clocks derived from system clock
// - clock output, optional toggle halving
// - idle stops only the CPU clock
// - slow-down divides CPU and peripheral clocks
// - power-down stops oscillator and PLL
// - start active; modes entered from active
// - components may be stopped one by one
// - boot levels latched until next reset
`timescale 1ns/1ps
module bcpc_top import bcpc_pkg::*; #(
  parameter logic [19:0] EXT_OSC_KHZ = 20'h02710,
  parameter logic [19:0] VCO_FREE_KHZ = 20'h0C350
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // boot pins and flash status
  input wire logic boot_select_pin,
  input wire logic test_mode_pin,
  input wire logic port_zero_pin_zero,
  input wire logic flash_protected,
  // boot result
  output logic [2:0] boot_mode,
  output logic boot_valid,
  output logic [15:0] pc_start,
  // oscillator and pll
  input wire logic osc_running,
  input wire logic pll_locked,
  input wire logic wake_pin,
  output logic osc_ext_select,
  output logic osc_enable,
  output logic pll_enable,
  output logic osc_disconnect,
  output logic vco_bypass,
  output logic [5:0] feedback_div,
  output logic [19:0] sys_freq_khz,
  // clock enables
  output logic cpu_core_clock_en,
  output logic periph_clock_en,
  output logic capture_unit_clock_en,
  output logic flash_fast_clock_en,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  // status
  output logic [1:0] pwr_mode,
  output logic irq
);
  // ********************************************************
  // elaboration checks
  // ********************************************************
  if (EXT_OSC_KHZ == 20'h00000 || VCO_FREE_KHZ == 20'h00000) begin : g_bad_osc
    $error("oscillator figures must be nonzero");
  end

  // ********************************************************
  // input synchronisers
  // ********************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic bsel_s, tms_s, p00_s, prot_s, osc_run_s, lock_s, wake_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {boot_select_pin, test_mode_pin, port_zero_pin_zero,
                  flash_protected, osc_running, pll_locked, wake_pin};
      sync2_r <= sync1_r;
    end
  end
  assign {bsel_s, tms_s, p00_s, prot_s, osc_run_s, lock_s, wake_s} = sync2_r;

  // ********************************************************
  // boot option latch
  // ********************************************************
  logic [1:0] boot_cnt_r;
  logic boot_valid_r;
  bcpc_boot_e boot_mode_r;
  logic boot_prot_r;
  logic dbg_refused_r;
  bcpc_boot_e boot_nxt;
  logic refuse_nxt;

  always_comb begin
    boot_nxt = BCPC_BOOT_USER;
    refuse_nxt = 1'b0;
    case ({bsel_s, tms_s})
      2'b10: boot_nxt = BCPC_BOOT_USER;
      2'b00: boot_nxt = BCPC_BOOT_LOADER;
      2'b01: begin
        // with the third pin high this code is undefined; run as user
        if (!p00_s && !prot_s) begin
          boot_nxt = BCPC_BOOT_DEBUG;
        end else begin
          refuse_nxt = !p00_s;
        end
      end
      2'b11: boot_nxt = p00_s ? BCPC_BOOT_USER : BCPC_BOOT_JTAG_USER;
      default: boot_nxt = BCPC_BOOT_USER;
    endcase
  end

  // levels are caught once the synchronisers hold post-reset samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 2'h0;
      boot_valid_r <= 1'b0;
      boot_mode_r <= BCPC_BOOT_USER;
      boot_prot_r <= 1'b0;
      dbg_refused_r <= 1'b0;
    end else if (!boot_valid_r) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
      if (boot_cnt_r == BOOT_SETTLE_CYC) begin
        boot_valid_r <= 1'b1;
        boot_mode_r <= boot_nxt;
        boot_prot_r <= prot_s;
        dbg_refused_r <= refuse_nxt;
      end
    end
  end

  // ********************************************************
  // register file
  // ********************************************************
  logic osc_disc_r, vco_byp_r, ext_osc_r;
  logic [5:0] fbdiv_r;
  logic [3:0] slow_r;
  bcpc_pwr_e pwr_r;
  logic [NUM_COMP-1:0] stop_r;
  logic co_en_r, co_toggle_r, co_src_r;
  logic [NUM_IRQ-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_nxt;
  logic rd_hit;
  logic wr_en;
  bcpc_clkmode_e cmode;
  logic [19:0] freq_nxt;
  logic [19:0] freq_r;

  assign wr_en = psel && penable && pready_r && pwrite;

  always_comb begin
    rd_nxt = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      ADDR_CLK_CTRL: begin
        rd_nxt[CC_OSC_DISC_POS] = osc_disc_r;
        rd_nxt[CC_VCO_BYP_POS] = vco_byp_r;
        rd_nxt[CC_EXT_OSC_POS] = ext_osc_r;
        rd_nxt[CC_FBDIV_POS +: CC_FBDIV_W] = fbdiv_r;
        rd_nxt[CC_SLOW_POS +: CC_SLOW_W] = slow_r;
      end
      ADDR_PWR_CTRL: begin
        rd_nxt[PC_MODE_POS +: 2] = pwr_r;
        rd_nxt[PC_STOP_POS +: NUM_COMP] = stop_r;
      end
      ADDR_CLK_OUT_CTRL: begin
        rd_nxt[CO_EN_POS] = co_en_r;
        rd_nxt[CO_TOGGLE_POS] = co_toggle_r;
        rd_nxt[CO_SRC_POS] = co_src_r;
      end
      ADDR_BOOT_STAT: begin
        rd_nxt[BS_MODE_POS +: 3] = boot_mode_r;
        rd_nxt[BS_VALID_POS] = boot_valid_r;
        rd_nxt[BS_PROT_POS] = boot_prot_r;
        rd_nxt[BS_PC_POS +: 16] = PC_START;
      end
      ADDR_CLK_STAT: begin
        rd_nxt[CS_MODE_POS +: 2] = cmode;
        rd_nxt[CS_OSC_RUN_POS] = osc_run_s;
        rd_nxt[CS_LOCK_POS] = lock_s;
        rd_nxt[CS_PWR_POS +: 2] = pwr_r;
        rd_nxt[CS_FREQ_POS +: 20] = freq_r;
      end
      ADDR_IRQ_STAT: rd_nxt[NUM_IRQ-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_nxt[NUM_IRQ-1:0] = irq_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // answer comes in the first access cycle: no wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel && !penable && !pready_r;
      if (psel && !penable) begin
        pslverr_r <= !rd_hit;
        prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_disc_r <= 1'b0;
      vco_byp_r <= 1'b0;
      ext_osc_r <= 1'b0;
      fbdiv_r <= FBDIV_RST;
      slow_r <= SLOW_RST;
      co_en_r <= 1'b0;
      co_toggle_r <= 1'b0;
      co_src_r <= 1'b0;
      stop_r <= '0;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CLK_CTRL: begin
          osc_disc_r <= pwdata[CC_OSC_DISC_POS];
          vco_byp_r <= pwdata[CC_VCO_BYP_POS];
          ext_osc_r <= pwdata[CC_EXT_OSC_POS];
          fbdiv_r <= pwdata[CC_FBDIV_POS +: CC_FBDIV_W];
          slow_r <= pwdata[CC_SLOW_POS +: CC_SLOW_W];
        end
        ADDR_PWR_CTRL: stop_r <= pwdata[PC_STOP_POS +: NUM_COMP];
        ADDR_CLK_OUT_CTRL: begin
          co_en_r <= pwdata[CO_EN_POS];
          co_toggle_r <= pwdata[CO_TOGGLE_POS];
          co_src_r <= pwdata[CO_SRC_POS];
        end
        ADDR_IRQ_MASK: irq_mask_r <= pwdata[NUM_IRQ-1:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // power mode sequencing
  // ********************************************************
  logic [1:0] pwr_req;
  assign pwr_req = pwdata[PC_MODE_POS +: 2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= BCPC_PWR_ACTIVE;
    end else begin
      case (pwr_r)
        BCPC_PWR_ACTIVE: begin
          if (wr_en && paddr == ADDR_PWR_CTRL) begin
            pwr_r <= bcpc_pwr_e'(pwr_req);
          end
        end
        BCPC_PWR_IDLE, BCPC_PWR_SLOW: begin
          // in idle and slow modes only a write back to active is honoured
          if (wr_en && paddr == ADDR_PWR_CTRL && pwr_req == BCPC_PWR_ACTIVE) begin
            pwr_r <= BCPC_PWR_ACTIVE;
          end
        end
        BCPC_PWR_DOWN: begin
          if (wake_s) begin
            pwr_r <= BCPC_PWR_ACTIVE;
          end
        end
        default: pwr_r <= BCPC_PWR_ACTIVE;
      endcase
    end
  end

  // ********************************************************
  // clock mode and system frequency
  // ********************************************************
  logic [19:0] fosc;
  logic [25:0] prod;

  always_comb begin
    if (osc_disc_r) begin
      cmode = BCPC_CM_PLL_BASE;
    end else if (vco_byp_r) begin
      cmode = BCPC_CM_PRESCALER;
    end else begin
      cmode = BCPC_CM_PLL;
    end
  end

  assign fosc = ext_osc_r ? EXT_OSC_KHZ : INT_OSC_KHZ;

  always_comb begin
    prod = {6'h00, fosc};
    case (cmode)
      BCPC_CM_PLL_BASE: prod = {6'h00, VCO_FREE_KHZ};
      BCPC_CM_PRESCALER: prod = {6'h00, fosc};
      BCPC_CM_PLL: prod = 26'(fosc * fbdiv_r);
      default: prod = {6'h00, fosc};
    endcase
    freq_nxt = 20'(prod / (P_FACTOR * K_FACTOR));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_r <= 20'h00000;
    end else begin
      freq_r <= freq_nxt;
    end
  end

  // ********************************************************
  // fail-safe monitoring and interrupts
  // ********************************************************
  logic osc_run_d_r, lock_d_r, pd_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_d_r <= 1'b0;
      lock_d_r <= 1'b0;
      pd_d_r <= 1'b0;
    end else begin
      osc_run_d_r <= osc_run_s;
      lock_d_r <= lock_s;
      pd_d_r <= (pwr_r == BCPC_PWR_DOWN);
    end
  end

  // losses only count while the oscillator and pll are meant to run
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_OSC_FAIL] = osc_run_d_r && !osc_run_s && !pd_d_r;
    irq_evt[IRQ_LOCK_LOST] = lock_d_r && !lock_s && !pd_d_r &&
                             (cmode == BCPC_CM_PLL);
    irq_evt[IRQ_DBG_REFUSED] = dbg_refused_r && !boot_valid_r ? 1'b0 :
                               (boot_cnt_r == BOOT_SETTLE_CYC) && refuse_nxt &&
                               !boot_valid_r;
    irq_evt[IRQ_WAKE] = pd_d_r && (pwr_r == BCPC_PWR_ACTIVE);
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[NUM_IRQ-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  // ********************************************************
  // clock distribution
  // ********************************************************
  bcpc_div_if base_if ();
  bcpc_div_if slow_if ();

  // peripheral tick is the system tick divided by three
  assign base_if.tick_in = 1'b1;
  assign base_if.div = PERIPH_DIV;
  assign slow_if.tick_in = base_if.tick_out;
  assign slow_if.div = {4'h0, slow_r};

  bcpc_divider u_base_div (
    .clk (clk),
    .rst_n (rst_n),
    .d (base_if.slave)
  );

  bcpc_divider u_slow_div (
    .clk (clk),
    .rst_n (rst_n),
    .d (slow_if.slave)
  );

  logic running;
  logic slow_tick;
  logic [NUM_COMP-1:0] comp_tick;
  logic [NUM_COMP-1:0] comp_en_r;
  logic cpu_en_r;
  logic co_pin_r;
  logic co_tick;

  assign running = (pwr_r != BCPC_PWR_DOWN);
  assign slow_tick = (pwr_r == BCPC_PWR_SLOW) ? slow_if.tick_out
                                              : base_if.tick_out;
  // components: 0 peripherals, 1 capture unit, 2 flash fast, 3 clock out
  assign comp_tick = {1'b1, 1'b1, slow_tick, slow_tick};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COMP; gi++) begin : g_comp
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          comp_en_r[gi] <= 1'b0;
        end else begin
          comp_en_r[gi] <= running && !stop_r[gi] && comp_tick[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_en_r <= 1'b0;
    end else begin
      cpu_en_r <= running && (pwr_r != BCPC_PWR_IDLE) && slow_tick;
    end
  end

  // ********************************************************
  // clock output pin
  // ********************************************************
  assign co_tick = co_src_r ? base_if.tick_out : 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      co_pin_r <= 1'b0;
    end else if (!co_en_r || !comp_en_r[3] && !co_toggle_r) begin
      co_pin_r <= co_toggle_r ? co_pin_r : 1'b0;
    end else if (co_toggle_r) begin
      if (co_tick && running && !stop_r[3]) begin
        co_pin_r <= !co_pin_r;
      end
    end else begin
      co_pin_r <= co_tick;
    end
  end

  logic co_oe_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      co_oe_r <= 1'b0;
    end else begin
      co_oe_r <= co_en_r;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  logic osc_en_r, pll_en_r, irq_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_r <= 1'b1;
      pll_en_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      osc_en_r <= running;
      pll_en_r <= running;
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign boot_mode = boot_mode_r;
  assign boot_valid = boot_valid_r;
  assign pc_start = PC_START;
  assign osc_ext_select = ext_osc_r;
  assign osc_enable = osc_en_r;
  assign pll_enable = pll_en_r;
  assign osc_disconnect = osc_disc_r;
  assign vco_bypass = vco_byp_r;
  assign feedback_div = fbdiv_r;
  assign sys_freq_khz = freq_r;
  assign cpu_core_clock_en = cpu_en_r;
  assign periph_clock_en = comp_en_r[0];
  assign capture_unit_clock_en = comp_en_r[1];
  assign flash_fast_clock_en = comp_en_r[2];
  assign clock_output_pin_o = co_pin_r;
  assign clock_output_pin_oe = co_oe_r;
  assign pwr_mode = pwr_r;
  assign irq = irq_r;
endmodule

// *** bcpc_top_chk.sv ***
// concurrent checks on the ports of the boot, clock and power control top
`timescale 1ns/1ps
module bcpc_top_chk import bcpc_pkg::*; #(
  parameter logic [19:0] EXT_OSC_KHZ = 20'h02710,
  parameter logic [19:0] VCO_FREE_KHZ = 20'h0C350
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // boot
  input wire logic boot_select_pin,
  input wire logic test_mode_pin,
  input wire logic port_zero_pin_zero,
  input wire logic flash_protected,
  input wire logic [2:0] boot_mode,
  input wire logic boot_valid,
  input wire logic [15:0] pc_start,
  // clocks and power
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic osc_disconnect,
  input wire logic [19:0] sys_freq_khz,
  input wire logic cpu_core_clock_en,
  input wire logic [1:0] pwr_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // sequences and properties
  // ****
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_act3; (pwr_mode == BCPC_PWR_ACTIVE)[*3]; endsequence
  property p_answer; s_setup |=> s_answer; endproperty
  property p_pc; pc_start == PC_START; endproperty
  property p_boot_hold; boot_valid |=> boot_valid && $stable(boot_mode); endproperty
  // the third strap only matters with the test pin high; that combination is left out
  property p_boot_sel;
    $rose(boot_valid) && !(test_mode_pin && port_zero_pin_zero) |-> boot_mode == (test_mode_pin ?
      (boot_select_pin ? 3'h3 : (flash_protected ? 3'h0 : 3'h2)) : {2'b0, !boot_select_pin});
  endproperty
  property p_down; (pwr_mode == BCPC_PWR_DOWN)[*2] |-> !osc_enable && !pll_enable; endproperty
  property p_idle; (pwr_mode == BCPC_PWR_IDLE)[*2] |-> !cpu_core_clock_en; endproperty
  property p_rate; (s_act3 ##0 cpu_core_clock_en) ##1 s_act3 |-> cpu_core_clock_en; endproperty
  property p_base; osc_disconnect[*3] |-> sys_freq_khz == VCO_FREE_KHZ / K_FACTOR; endproperty
  a_answer: assert property (p_answer) else $error("pready not one cycle after setup");
  a_pc: assert property (p_pc) else $error("start address wrong");
  a_boot_hold: assert property (p_boot_hold) else $error("boot result moved");
  a_boot_sel: assert property (p_boot_sel) else $error("boot mode wrong");
  a_down: assert property (p_down) else $error("osc or pll on in power-down");
  a_idle: assert property (p_idle) else $error("cpu clock runs in idle");
  a_rate: assert property (p_rate) else $error("cpu clock rate wrong");
  a_base: assert property (p_base) else $error("base mode frequency wrong");
endmodule
bind bcpc_top bcpc_top_chk #(.EXT_OSC_KHZ(EXT_OSC_KHZ), .VCO_FREE_KHZ(VCO_FREE_KHZ)) u_chk (
  .clk, .rst_n, .psel, .penable, .pready, .boot_select_pin, .test_mode_pin,
  .port_zero_pin_zero, .flash_protected, .boot_mode, .boot_valid, .pc_start, .osc_enable,
  .pll_enable, .osc_disconnect, .sys_freq_khz, .cpu_core_clock_en, .pwr_mode
);

// *** tb.sv ***
// self-checking testbench for the boot, clock and power control block
`timescale 1ns/1ps
module tb import bcpc_pkg::*; ;
  localparam logic [19:0] EXT_KHZ = 20'h01F40;
  localparam logic [19:0] VCO_KHZ = 20'h0C350;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic osc_running = 1'b1, pll_locked = 1'b1, wake_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, boot_select_pin, test_mode_pin, port_zero_pin_zero, flash_protected;
  logic boot_valid, osc_ext_select, osc_enable, pll_enable, osc_disconnect, vco_bypass, irq;
  logic cpu_core_clock_en, periph_clock_en, capture_unit_clock_en, flash_fast_clock_en;
  logic clock_output_pin_o, clock_output_pin_oe;
  logic [2:0] boot_mode;
  logic [15:0] pc_start;
  logic [5:0] feedback_div;
  logic [19:0] sys_freq_khz;
  logic [1:0] pwr_mode;
  logic [3:0] cfg = 4'h8;
  logic [4:0] en;
  logic [3:0] bc[5] = '{4'h8, 4'h0, 4'h4, 4'hC, 4'h5};
  logic [2:0] bm[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0};
  logic [32:0] exp_q[$];
  int errors = 0, checks_done = 0, cyc = 0;
  assign en = {clock_output_pin_o, flash_fast_clock_en, capture_unit_clock_en, periph_clock_en,
    cpu_core_clock_en};
  bcpc_top #(.EXT_OSC_KHZ(EXT_KHZ), .VCO_FREE_KHZ(VCO_KHZ)) dut (.*);
  bcpc_strap_model u_pins (.clk, .cfg, .boot_select_pin, .test_mode_pin, .port_zero_pin_zero,
    .flash_protected);
  always #50 clk = ~clk;
  // ****
  // tasks
  // ****
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cnt(input int s, output int k);
    k = 0;
    repeat (12) begin
      @(posedge clk);
      k += (en[s] === 1'b1);
    end
  endtask
  task automatic pw(input logic [31:0] v, input int e[5]);
    int k;
    apb(1'b1, ADDR_PWR_CTRL, v);
    repeat (4) @(posedge clk);
    check(33'(pwr_mode), 33'(v[1:0]));
    for (int s = 0; s < 5; s++) begin
      cnt(s, k);
      if (e[s] >= 0) check(33'(k), 33'(e[s]));
    end
  endtask
  // ****
  // read monitor, timeout and sequence
  // ****
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end
  initial begin
    logic [3:0] c;
    logic [5:0] n;
    int f;
    void'($urandom(94071));
    for (int i = 0; i < 5; i++) begin
      c = bc[i];
      if (!c[2]) c[1] = 1'($urandom);
      cfg <= c;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      rd(ADDR_BOOT_STAT, {16'h0000, 11'h0, c[0], 1'b1, bm[i]});
      cfg <= c ^ 4'hE;
      repeat (4) @(posedge clk);
      rd(ADDR_BOOT_STAT, {16'h0000, 11'h0, c[0], 1'b1, bm[i]});
    end
    $display("boot test done");
    rd(ADDR_CLK_CTRL, 32'h0001_1000);
    rd(ADDR_IRQ_STAT, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'hF);
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    rd(ADDR_IRQ_STAT, 32'h0);
    osc_running <= 1'b0;
    pll_locked <= 1'b0;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (6) @(posedge clk);
    check(33'(irq), 33'h0);
    rd(ADDR_IRQ_STAT, 32'h3);
    apb(1'b1, ADDR_IRQ_MASK, 32'hF);
    repeat (3) @(posedge clk);
    check(33'(irq), 33'h1);
    osc_running <= 1'b1;
    pll_locked <= 1'b1;
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    repeat (3) @(posedge clk);
    check(33'(irq), 33'h0);
    rd(8'h1C, {1'b1, 32'h0});
    $display("irq test done");
    for (int i = 0; i < 5; i++) begin
      n = 6'($urandom_range(63, 1));
      apb(1'b1, ADDR_CLK_CTRL, {12'h0, 4'h1, 2'h0, n, 5'h0, 3'(i)});
      repeat (4) @(posedge clk);
      f = (i[0] ? VCO_KHZ : (i[2] ? EXT_KHZ : INT_OSC_KHZ) * (i[1] ? 1 : n)) / (P_FACTOR * K_FACTOR);
      rd(ADDR_CLK_STAT, {4'h0, 20'(f), 6'h3, 2'(i[0] ? 2 : i[1])});
      check(33'({osc_ext_select, vco_bypass, osc_disconnect, feedback_div}), 33'({3'(i), n}));
    end
    $display("clock mode test done");
    apb(1'b1, ADDR_CLK_CTRL, 32'h0002_1000);
    apb(1'b1, ADDR_CLK_OUT_CTRL, 32'h3);
    pw(32'h0, '{4, 4, 4, 12, 6});
    check(33'(clock_output_pin_oe), 33'h1);
    pw(32'h1, '{0, 4, 4, -1, -1});
    pw(32'h0, '{4, 4, 4, 12, -1});
    pw(32'h2, '{2, 2, 2, -1, -1});
    pw(32'h50, '{4, 0, 4, 0, -1});
    pw(32'h3, '{0, 0, 0, -1, -1});
    check(33'({osc_enable, pll_enable}), 33'h0);
    apb(1'b1, ADDR_PWR_CTRL, 32'h0);
    @(posedge clk);
    check(33'(pwr_mode), 33'h3);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b0;
    repeat (4) @(posedge clk);
    check(33'({pwr_mode, osc_enable}), 33'h1);
    rd(ADDR_IRQ_STAT, 32'h8);
    apb(1'b1, ADDR_CLK_OUT_CTRL, 32'h5);
    pw(32'h0, '{4, 4, 4, 12, 4});
    $display("power test done");
    repeat (4) @(posedge clk);
    results();
  end
endmodule
